/* File: core/pad_config_freq_status_regs.v */
// Pad configuration, pixel clock frequency counter and link status registers.
// Assumes an AHB-Lite master on hclk; all pad and status inputs are synchronous to hclk.
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pad_regs.vh"
module pad_config_freq_status_regs (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	output reg         irq,
	input  wire        pixel_clk_edge,
	input  wire        tx_two_link_flag,
	input  wire        rx_two_link_flag,
	input  wire        audio_pll_locked,
	input  wire        signal_detected,
	input  wire        cdr_lock_ch0,
	input  wire        cdr_lock_ch1,
	input  wire        func_pin9,
	input  wire        func_pin0,
	input  wire        func_second_port_pin0,
	input  wire        remote_pin0,
	input  wire        remote_second_port_pin0,
	input  wire        pin9_in,
	input  wire        pin0_in,
	input  wire        second_port_pin0_in,
	output reg         pin9_out,
	output reg         pin9_oe_n,
	output reg         pin0_out,
	output reg         pin0_oe_n,
	output reg         second_port_pin0_out,
	output reg         second_port_pin0_oe_n,
	output reg  [2:0]  pad_in_levels
);
	// Pad decision: returns {drive level, output enable low}
	function [1:0] pad_drive;
		input       p_dir;
		input       p_en;
		input       p_level;
		input       p_remote;
		input       r_val;
		input       g_dir;
		input       g_en;
		input       g_level;
		input       f_val;
		reg   [1:0] mode;
		begin
			mode = {p_dir, p_en};
			if (p_remote) begin
				pad_drive = {r_val, 1'b0};
			end else if (p_en) begin
				// Pin GPIO setting wins over global
				if (mode == `MODE_PIN_OUT)
					pad_drive = {p_level, 1'b0};
				else
					pad_drive = 2'b01;
			end else if (g_en) begin
				if ({g_dir, g_en} == `MODE_PIN_OUT)
					pad_drive = {g_level, 1'b0};
				else
					pad_drive = 2'b01;
			end else if ({g_dir, g_en} == `MODE_TRISTATE || mode == `MODE_TRISTATE) begin
				pad_drive = 2'b01;
			end else begin
				pad_drive = {f_val, 1'b0};
			end
		end
	endfunction

	reg  [7:0]  global_pad_ff;
	reg  [3:0]  pin0_cfg_ff;
	reg  [3:0]  pin0b_cfg_ff;
	reg         port_sel_ff;
	reg  [7:0]  freq_count_ff;
	reg  [7:0]  window_ff;
	reg  [2:0]  osc_div_ff;
	reg         counting_ff;
	reg  [7:0]  status_ff;
	reg  [`IRQ_WIDTH-1:0] irq_status_ff;
	reg  [`IRQ_WIDTH-1:0] irq_mask_ff;
	reg         wr_pend_ff;
	reg  [7:0]  wr_idx_ff;

	reg  [7:0]  nxt_status;
	reg  [7:0]  rd_mux;
	reg  [`IRQ_WIDTH-1:0] nxt_irq_status;
	reg  [`IRQ_WIDTH-1:0] irq_events;
	reg  [1:0]  d9;
	reg  [1:0]  d0;
	reg  [1:0]  db;
	wire        addr_phase;
	wire [7:0]  addr_idx;
	wire        wr_now;
	wire        lock_now;
	wire [3:0]  sel_cfg;

	assign addr_phase = hsel && htrans[1] && hready;
	assign addr_idx   = haddr[9:2];
	assign wr_now     = wr_pend_ff;
	assign sel_cfg    = port_sel_ff ? pin0b_cfg_ff : pin0_cfg_ff;
	assign lock_now   = rx_two_link_flag ? (cdr_lock_ch0 && cdr_lock_ch1) : cdr_lock_ch0;

	// Live status image
	always @* begin
		nxt_status = 8'h00;
		nxt_status[`ST_TX_DUAL_BIT]    = tx_two_link_flag;
		nxt_status[`ST_RX_DUAL_BIT]    = rx_two_link_flag;
		nxt_status[`ST_AUDIO_LOCK_BIT] = audio_pll_locked;
		nxt_status[`ST_SIGNAL_BIT]     = signal_detected;
		nxt_status[`ST_LOCK_BIT]       = lock_now;
	end

	// Read data selection
	always @* begin
		rd_mux = 8'h00;
		case (addr_idx)
			`IDX_GLOBAL_PAD:  rd_mux = global_pad_ff & `GLOBAL_PAD_WMASK;
			`IDX_FREQ_COUNT:  rd_mux = freq_count_ff;
			`IDX_LINK_STATUS: rd_mux = status_ff;
			`IDX_PIN0_CONFIG: rd_mux = {`SILICON_REVISION, sel_cfg};
			`IDX_PORT_SELECT: rd_mux = {7'h00, port_sel_ff};
			`IDX_IRQ_STATUS:  rd_mux = {{(8-`IRQ_WIDTH){1'b0}}, irq_status_ff};
			`IDX_IRQ_MASK:    rd_mux = {{(8-`IRQ_WIDTH){1'b0}}, irq_mask_ff};
			default:          rd_mux = 8'h00;
		endcase
	end

	// Interrupt events; set wins over clear
	always @* begin
		irq_events = {`IRQ_WIDTH{1'b0}};
		irq_events[`IRQ_COUNT_DONE_BIT] = counting_ff && (window_ff == 8'h00);
		irq_events[`IRQ_LOCK_LOST_BIT]  = status_ff[`ST_LOCK_BIT] && !lock_now;
		irq_events[`IRQ_SIGNAL_CHG_BIT] = status_ff[`ST_SIGNAL_BIT] != signal_detected;
		nxt_irq_status = irq_status_ff;
		if (wr_now && wr_idx_ff == `IDX_IRQ_STATUS)
			nxt_irq_status = irq_status_ff & ~hwdata[`IRQ_WIDTH-1:0];
		nxt_irq_status = nxt_irq_status | irq_events;
	end

	// Pad decisions
	always @* begin
		// Pin 9 has no far-end control
		d9 = pad_drive(
			global_pad_ff[`PIN9_DIR_BIT],
			global_pad_ff[`PIN9_EN_BIT],
			global_pad_ff[`PIN9_LEVEL_BIT],
			1'b0,
			1'b0,
			global_pad_ff[`GLB_DIR_BIT],
			global_pad_ff[`GLB_EN_BIT],
			global_pad_ff[`GLB_LEVEL_BIT],
			func_pin9
		);
		// First port pin 0
		d0 = pad_drive(
			pin0_cfg_ff[`PIN_DIR_BIT],
			pin0_cfg_ff[`PIN_EN_BIT],
			pin0_cfg_ff[`PIN_LEVEL_BIT],
			pin0_cfg_ff[`PIN_REMOTE_BIT],
			remote_pin0,
			global_pad_ff[`GLB_DIR_BIT],
			global_pad_ff[`GLB_EN_BIT],
			global_pad_ff[`GLB_LEVEL_BIT],
			func_pin0
		);
		// Second port pin 0
		db = pad_drive(
			pin0b_cfg_ff[`PIN_DIR_BIT],
			pin0b_cfg_ff[`PIN_EN_BIT],
			pin0b_cfg_ff[`PIN_LEVEL_BIT],
			pin0b_cfg_ff[`PIN_REMOTE_BIT],
			remote_second_port_pin0,
			global_pad_ff[`GLB_DIR_BIT],
			global_pad_ff[`GLB_EN_BIT],
			global_pad_ff[`GLB_LEVEL_BIT],
			func_second_port_pin0
		);
	end

	// Bus slave and register writes
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata        <= 32'h00000000;
			hreadyout     <= 1'b0;
			hresp         <= 1'b0;
			wr_pend_ff    <= 1'b0;
			wr_idx_ff     <= 8'h00;
			global_pad_ff <= `GLOBAL_PAD_RESET;
			pin0_cfg_ff   <= `PIN0_CFG_RESET;
			pin0b_cfg_ff  <= `PIN0_CFG_RESET;
			port_sel_ff   <= 1'b0;
			irq_mask_ff   <= {`IRQ_WIDTH{1'b0}};
		end else begin
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
			wr_pend_ff <= addr_phase && hwrite;
			if (addr_phase)
				wr_idx_ff <= addr_idx;
			if (addr_phase && !hwrite)
				hrdata <= {24'h000000, rd_mux};
			if (wr_now) begin
				case (wr_idx_ff)
					`IDX_GLOBAL_PAD:  global_pad_ff <= hwdata[7:0] & `GLOBAL_PAD_WMASK;
					`IDX_PIN0_CONFIG: begin
						if (port_sel_ff)
							pin0b_cfg_ff <= hwdata[3:0];
						else
							pin0_cfg_ff <= hwdata[3:0];
					end
					`IDX_PORT_SELECT: port_sel_ff <= hwdata[0];
					`IDX_IRQ_MASK:    irq_mask_ff <= hwdata[`IRQ_WIDTH-1:0];
					default:          ;
				endcase
			end
		end
	end

	// Frequency counter window in oscillator periods
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			freq_count_ff <= 8'h00;
			window_ff     <= 8'h00;
			osc_div_ff    <= 3'h0;
			counting_ff   <= 1'b0;
		end else if (wr_now && wr_idx_ff == `IDX_FREQ_COUNT) begin
			freq_count_ff <= 8'h00;
			window_ff     <= hwdata[7:0];
			osc_div_ff    <= 3'h0;
			counting_ff   <= 1'b1;
		end else if (counting_ff) begin
			if (window_ff == 8'h00) begin
				counting_ff <= 1'b0;
			end else begin
				if (pixel_clk_edge && freq_count_ff != `FREQ_MAX)
					freq_count_ff <= freq_count_ff + 8'h01;
				if (osc_div_ff == `OSC_DIV_LAST) begin
					osc_div_ff <= 3'h0;
					window_ff  <= window_ff - 8'h01;
				end else begin
					osc_div_ff <= osc_div_ff + 3'h1;
				end
			end
		end
	end

	// Status, interrupt and pad outputs
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_ff             <= 8'h00;
			irq_status_ff         <= {`IRQ_WIDTH{1'b0}};
			irq                   <= 1'b0;
			pin9_out              <= 1'b0;
			pin9_oe_n             <= 1'b1;
			pin0_out              <= 1'b0;
			pin0_oe_n             <= 1'b1;
			second_port_pin0_out  <= 1'b0;
			second_port_pin0_oe_n <= 1'b1;
			pad_in_levels         <= 3'h0;
		end else begin
			status_ff             <= nxt_status;
			irq_status_ff         <= nxt_irq_status;
			irq                   <= |(nxt_irq_status & irq_mask_ff);
			pin9_out              <= d9[1];
			pin9_oe_n             <= d9[0];
			pin0_out              <= d0[1];
			pin0_oe_n             <= d0[0];
			second_port_pin0_out  <= db[1];
			second_port_pin0_oe_n <= db[0];
			pad_in_levels         <= {second_port_pin0_in, pin0_in, pin9_in};
		end
	end
endmodule // pad_config_freq_status_regs
`default_nettype wire

/* File: pkg/pad_regs.vh */
// Constants for the pad, frequency counter and status register bank.
// Operation
// - Global level driven when pin not GPIO; the code drives it only with global set to 01 out and pin not remote
// - Global 00 func, 10 tri, 01 out, 11 in
// - Per-pin GPIO setting overrides global setting
// - Local level driven when GPIO output, not remote
// - Pin 00 func, 10 tri, 01 out, 11 in
// - Far-end control bit makes pin remote output
// - Write starts window of value times 50ns
// - Read returns edges counted in last window
// - Counter saturates at 0xff
// - Status bit 5 shows transmit dual link
// - Status bit 4 shows receive dual link
// - Status bit 3 shows audio PLL lock
// - Status bit 1 shows serial signal detected
// - Status bit 0 lock; dual needs both
// - Second port select steers pin-0 register
`ifndef PAD_REGS_VH
`define PAD_REGS_VH
`define IDX_GLOBAL_PAD      8'h1a
`define IDX_FREQ_COUNT      8'h1b
`define IDX_LINK_STATUS     8'h1c
`define IDX_PIN0_CONFIG     8'h1d
`define IDX_PORT_SELECT     8'h30
`define IDX_IRQ_STATUS      8'h31
`define IDX_IRQ_MASK        8'h32
`define GLOBAL_PAD_RESET    8'h00
`define GLOBAL_PAD_WMASK    8'hbb
`define PIN0_CFG_RESET      4'h3
`define SILICON_REVISION    4'h5
`define GLB_LEVEL_BIT       7
`define GLB_DIR_BIT         5
`define GLB_EN_BIT          4
`define PIN9_LEVEL_BIT      3
`define PIN9_DIR_BIT        1
`define PIN9_EN_BIT         0
`define PIN_LEVEL_BIT       3
`define PIN_REMOTE_BIT      2
`define PIN_DIR_BIT         1
`define PIN_EN_BIT          0
`define ST_TX_DUAL_BIT      5
`define ST_RX_DUAL_BIT      4
`define ST_AUDIO_LOCK_BIT   3
`define ST_SIGNAL_BIT       1
`define ST_LOCK_BIT         0
`define IRQ_COUNT_DONE_BIT  0
`define IRQ_LOCK_LOST_BIT   1
`define IRQ_SIGNAL_CHG_BIT  2
`define IRQ_WIDTH           3
`define OSC_PERIOD_NS       50
`define HCLK_PERIOD_NS      10
`define OSC_CYCLES          ((`OSC_PERIOD_NS + `HCLK_PERIOD_NS - 1) / `HCLK_PERIOD_NS)
`define OSC_DIV_LAST        3'h4
`define FREQ_MAX            8'hff
`define MODE_FUNC           2'b00
`define MODE_PIN_OUT        2'b01
`define MODE_TRISTATE       2'b10
`define MODE_PIN_IN         2'b11
`endif

/* File: tb/pad_regs_sva.sv */
// Checker for the pad register bank: bus read-back and pin 9 pad drive.
// Assumes it is bound to the design top and that hclk is the only clock.
`timescale 1ns/1ps
`default_nettype none
module pad_regs_sva (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        func_pin9,
	input wire logic        pin9_out,
	input wire logic        pin9_oe_n
);
	logic       wr_ff;
	logic [7:0] g_ff;
	// Shadow of the global pad register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff <= 1'b0;
			g_ff  <= 8'h00;
		end else begin
			if (wr_ff) g_ff <= hwdata[7:0] & 8'hbb;
			if (hready) wr_ff <= hsel && htrans[1] && hwrite && haddr == 32'h68;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_drive(v);
		!pin9_oe_n && pin9_out == v;
	endsequence
	a_pin9_local: assert property (g_ff[1:0] == 2'b01 |=> s_drive($past(g_ff[3])))
		else $error("pin9 local level wrong");
	a_pin9_input: assert property (g_ff[1:0] == 2'b11 |=> pin9_oe_n)
		else $error("pin9 input driven");
	a_global_level: assert property (!g_ff[0] && g_ff[5:4] == 2'b01 |=> s_drive($past(g_ff[7])))
		else $error("global level wrong");
	a_global_input: assert property (!g_ff[0] && g_ff[5:4] == 2'b11 |=> pin9_oe_n)
		else $error("global input driven");
	a_tri_state: assert property (!g_ff[0] && !g_ff[4] && (g_ff[1] || g_ff[5]) |=> pin9_oe_n)
		else $error("tristate driven");
	a_func_drive: assert property ((g_ff & 8'h33) == 8'h00 |=> s_drive($past(func_pin9)))
		else $error("functional value wrong");
	a_read_back: assert property (hsel && htrans[1] && hready && !hwrite && haddr == 32'h68 |=>
		hrdata[7:0] == $past(g_ff)) else $error("global read back wrong");
	a_upper_zero: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
endmodule // pad_regs_sva
`default_nettype wire

/* File: tb/far_end_model.sv */
// Far-end serializer model: pixel clock edge pulses and remote pin values.
// Assumes rate and lvl are driven synchronously to clk.
`timescale 1ns/1ps
`default_nettype none
module far_end_model (
	input  wire logic       clk,
	input  wire logic [1:0] rate,
	input  wire logic       lvl,
	output var  logic       edge_p,
	output var  logic       rem0,
	output var  logic       rem1
);
	// Rate 1 every cycle, 2 every other cycle, else none
	always @(posedge clk) begin
		edge_p <= rate == 2'd1 || (rate == 2'd2 && !edge_p);
		rem0   <= lvl;
		rem1   <= !lvl;
	end
endmodule // far_end_model
`default_nettype wire

/* File: tb/pad_config_freq_status_regs_tb.sv */
// Self-checking bench for the pad, frequency counter and status registers.
// Assumes the design, far-end model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "pad_regs.vh"
module pad_config_freq_status_regs_tb;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, lvl = 1, fv = 1;
	logic [1:0]  htrans = 0, rate = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic        hreadyout, hresp, irq, edge_p, rem0, rem1;
	logic [5:0]  st = 0, po;
	logic [2:0]  pin_in = 3'b101, pad_lv;
	int          fail_count = 0, check_count = 0;
	localparam logic [31:0] AG = `IDX_GLOBAL_PAD*4, AF = `IDX_FREQ_COUNT*4, AS = `IDX_LINK_STATUS*4;
	localparam logic [31:0] AP = `IDX_PIN0_CONFIG*4, AX = `IDX_PORT_SELECT*4;
	localparam logic [31:0] AI = `IDX_IRQ_STATUS*4, AM = `IDX_IRQ_MASK*4;
	localparam logic [7:0] GV [9] = '{8'h00, 8'h01, 8'h09, 8'h03, 8'h90, 8'h10, 8'h30, 8'h20, 8'h02};
	localparam logic [13:0] PT [13] = '{{8'h00, 6'h25}, {8'h00, 6'h04}, {8'h00, 6'h0e}, {8'h00, 6'h0a},
		{8'h00, 6'h01}, {8'h00, 6'h11}, {8'h00, 6'h1d}, {8'h90, 6'h04}, {8'h90, 6'h01}, {8'h10, 6'h00},
		{8'h30, 6'h02}, {8'h20, 6'h02}, {8'h20, 6'h04}};
	localparam logic [13:0] ST [7] = '{{6'h20, 8'h20}, {6'h12, 8'h10}, {6'h13, 8'h11}, {6'h02, 8'h01},
		{6'h08, 8'h08}, {6'h04, 8'h02}, {6'h3f, 8'h3b}};
	pad_config_freq_status_regs u_pad_config_freq_status_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .pixel_clk_edge(edge_p),
		.tx_two_link_flag(st[5]), .rx_two_link_flag(st[4]), .audio_pll_locked(st[3]), .signal_detected(st[2]),
		.cdr_lock_ch0(st[1]), .cdr_lock_ch1(st[0]), .func_pin9(fv), .func_pin0(fv), .func_second_port_pin0(fv),
		.remote_pin0(rem0), .remote_second_port_pin0(rem1), .pin9_in(pin_in[0]), .pin0_in(pin_in[1]),
		.second_port_pin0_in(pin_in[2]), .pin9_out(po[0]), .pin9_oe_n(po[1]), .pin0_out(po[2]),
		.pin0_oe_n(po[3]), .second_port_pin0_out(po[4]), .second_port_pin0_oe_n(po[5]), .pad_in_levels(pad_lv));
	far_end_model u_far_end_model (.clk(hclk), .rate(rate), .lvl(lvl), .edge_p(edge_p), .rem0(rem0), .rem1(rem1));
	always #5 hclk = ~hclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		chk(r, e);
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#50us;
		fail_count++;
		test_done();
	end
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rd(AG, 0);
		rd(AF, 0);
		rd(AS, 0);
		rd(AP, {`SILICON_REVISION, `PIN0_CFG_RESET});
		chk(pad_lv, 3'b101);
		chk(hresp, 1'b0);
		bus(1'b1, 32'h100, 8'hff);
		rd(32'h100, 0);
		bus(1'b1, AG, 8'hff);
		rd(AG, 8'hbb);
		bus(1'b1, AP, 8'hff);
		rd(AP, {`SILICON_REVISION, 4'hf});
		foreach (GV[i]) begin
			bus(1'b1, AG, GV[i]);
			w(2);
		end
		foreach (PT[i]) begin
			bus(1'b1, AG, PT[i][13:6]);
			bus(1'b1, AP, {4'h0, PT[i][5:2]});
			w(2);
			chk(po[3], PT[i][1]);
			if (!PT[i][1]) chk(po[2], PT[i][0]);
		end
		bus(1'b1, AG, 8'h00);
		bus(1'b1, AX, 8'h01);
		bus(1'b1, AP, 8'h09);
		w(2);
		chk(po[5:2], 4'b0100);
		rd(AP, {`SILICON_REVISION, 4'h9});
		bus(1'b1, AX, 8'h00);
		rd(AP, {`SILICON_REVISION, 4'h1});
		foreach (ST[i]) begin
			@(posedge hclk) st <= ST[i][13:8];
			w(3);
			rd(AS, ST[i][7:0]);
		end
		rd(AI, 32'h6);
		chk(irq, 1'b0);
		bus(1'b1, AM, 8'h06);
		w(2);
		chk(irq, 1'b1);
		bus(1'b1, AI, 8'h06);
		w(2);
		chk(irq, 1'b0);
		bus(1'b1, AM, 8'h01);
		@(posedge hclk) rate <= 2'd2;
		bus(1'b1, AF, 8'd10);
		w(55);
		chk(irq, 1'b1);
		rd(AF, 25);
		bus(1'b1, AI, 8'h01);
		w(2);
		chk(irq, 1'b0);
		@(posedge hclk) rate <= 2'd1;
		bus(1'b1, AF, 8'd60);
		w(305);
		rd(AF, 8'hff);
		bus(1'b1, AF, 8'd0);
		w(3);
		rd(AF, 0);
		test_done();
	end
endmodule // pad_config_freq_status_regs_tb
bind pad_config_freq_status_regs pad_regs_sva u_pad_regs_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hwdata, .hrdata, .func_pin9, .pin9_out, .pin9_oe_n);
`default_nettype wire
